/* File: sgw_params.svh */
`ifndef SGW_PARAMS_SVH
`define SGW_PARAMS_SVH
`define SGW_IDX_PORT_A    16'h002e
`define SGW_IDX_PORT_B    16'h004e
`define SGW_DAT_PORT_A    16'h002f
`define SGW_DAT_PORT_B    16'h004f
`define SGW_WDT_BASE_PORT 16'h0300
`define SGW_WDT_DATA_PORT 16'h0301
`define SGW_KEY_A         8'h87
`define SGW_KEY_B         8'h77
`define SGW_KEY_EXIT      8'haa
`define SGW_IDX_LDN       8'h07
`define SGW_IDX_ACT       8'h30
`define SGW_IDX_DIR       8'hf0
`define SGW_IDX_DATA      8'hf1
`define SGW_IDX_INV       8'hf2
`define SGW_LDN_GPIO      8'h07
`define SGW_LDN_WDT       8'h08
`define SGW_DIR_RST       8'hff
`define SGW_DATA_RST      8'h00
`define SGW_INV_RST       8'h00
`define SGW_UNIT_10MS     8'h00
`define SGW_UNIT_1S       8'h03
`define SGW_UNIT_1MIN     8'h05
`define SGW_CLK_MHZ       125
`define SGW_T_10MS_US     10000
`define SGW_TICK_10MS     (`SGW_CLK_MHZ * `SGW_T_10MS_US)
`define SGW_TICKS_PER_S   100
`define SGW_S_PER_MIN     60
`endif

/* File: sgw_pkg.sv */
package sgw_pkg;
    typedef enum logic [1:0] {
        SGW_LOCKED = 2'b00,
        SGW_KEY1   = 2'b01,
        SGW_OPEN   = 2'b11
    } sgw_cfg_state_t;
    typedef enum logic [1:0] {
        SGW_U_10MS = 2'b00,
        SGW_U_1S   = 2'b01,
        SGW_U_1MIN = 2'b11
    } sgw_unit_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } sgw_io_req_t;
endpackage

/* File: sgw_gpio_wdt.sv */
// Contract
// [R1] Direction bit one means input, resets ones
// [R2] Output lines: data bit read and written
// [R3] Input lines: data bit read-only
// [R4] Inversion bit flips value both directions
// [R5] Index port write-only at 2Eh/4Eh
// [R6] Data port read/write at 2Fh/4Fh
// [R7] Key 87H twice unlocks, interruptible
// [R8] AAH locks; data accesses ignored afterwards
// [R9] Index 07H selects logical device
// [R10] Device 7 holds F0, F1, F2 GPIO
// [R11] Key 77H twice also unlocks
// [R12] Device 8 index 30 write 01 enables
// [R13] Device 8 index 30 write 00 disables
// [R14] Base write 03: seconds, clears status
// [R15] Base write 00 10ms, 05 minutes
// [R16] Data port write loads count, starts
// [R17] Expiry resets CPU or interrupts
// [R18] Counts down per unit, zero expires
`timescale 1ns/100ps
`include "sgw_params.svh"
module sgw_gpio_wdt
    import sgw_pkg::*;
#(
    parameter int TICK_10MS = `SGW_TICK_10MS
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire sgw_io_req_t io_req,
    output logic [7:0]       io_rdata,
    output logic             io_rvalid,
    input  wire logic [7:0]  general_io_lines_in,
    output logic [7:0]       general_io_lines_out,
    output logic [7:0]       general_io_lines_oe,
    input  wire logic        wdt_irq_mode,
    output logic             wdt_cpu_reset,
    output logic             wdt_irq,
    output logic             wdt_timeout
);
    // Configuration state and registers
    sgw_cfg_state_t cfg_state;
    logic [7:0]     cfg_index;
    logic [7:0]     logical_device_select;
    logic [7:0]     gpio_direction;
    logic [7:0]     gpio_line_value;
    logic [7:0]     gpio_polarity_invert;
    logic [7:0]     pin_meta;
    logic [7:0]     pin_sync;
    // Watchdog state
    logic           wdt_active;
    logic           wdt_running;
    sgw_unit_t      wdt_unit;
    logic [7:0]     wdt_count;
    logic [31:0]    tick_cnt;
    logic [6:0]     unit_cnt;
    logic           unit_pulse;
    logic           expire;
    // Decoded host strobes
    logic           wr;
    logic           rd;
    logic           wr_idx;
    logic           wr_dat;
    logic           rd_dat;
    logic           unlocked;
    logic           sel_gpio;
    logic           sel_wdt;
    logic [7:0]     next_line_value;
    logic [7:0]     cfg_rdata;
    logic [6:0]     unit_len;

    // Decode of host I/O cycles
    assign wr       = io_req.wr && clk_en;
    assign rd       = io_req.rd && clk_en;
    assign unlocked = (cfg_state == SGW_OPEN);
    assign sel_gpio = (logical_device_select == `SGW_LDN_GPIO);
    assign sel_wdt  = (logical_device_select == `SGW_LDN_WDT);

    // Port decode; the data port is dead while locked
    always_comb begin
        wr_idx = 1'b0;
        wr_dat = 1'b0;
        rd_dat = 1'b0;
        if (io_req.addr == `SGW_IDX_PORT_A || io_req.addr == `SGW_IDX_PORT_B) begin
            wr_idx = wr; // [R5]
        end else if (io_req.addr == `SGW_DAT_PORT_A || io_req.addr == `SGW_DAT_PORT_B) begin
            wr_dat = wr && unlocked; // [R6] [R8]
            rd_dat = rd && unlocked; // [R6] [R8]
        end
    end

    // Unlock key sequence; cycles other than index-port writes are tolerated between keys, a non-key index write relocks
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_state <= SGW_LOCKED;
        end else if (wr_idx) begin
            // Exit key locks from any state
            if (io_req.wdata == `SGW_KEY_EXIT) begin
                cfg_state <= SGW_LOCKED; // [R8]
            end else if (!unlocked) begin
                if (io_req.wdata == `SGW_KEY_A || io_req.wdata == `SGW_KEY_B) begin
                    cfg_state <= (cfg_state == SGW_KEY1) ? SGW_OPEN : SGW_KEY1; // [R7] [R11]
                end else begin
                    cfg_state <= SGW_LOCKED;
                end
            end
        end
    end

    // Index register, only loaded while unlocked
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_index <= 8'h00;
        end else if (wr_idx && unlocked && io_req.wdata != `SGW_KEY_EXIT) begin
            cfg_index <= io_req.wdata; // [R5]
        end
    end

    // Logical device number
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            logical_device_select <= 8'h00;
        end else if (wr_dat && cfg_index == `SGW_IDX_LDN) begin
            logical_device_select <= io_req.wdata; // [R9]
        end
    end

    // GPIO direction and inversion
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpio_direction       <= `SGW_DIR_RST; // [R1]
            gpio_polarity_invert <= `SGW_INV_RST;
        end else if (wr_dat && sel_gpio) begin
            if (cfg_index == `SGW_IDX_DIR) begin
                gpio_direction <= io_req.wdata; // [R10]
            end else if (cfg_index == `SGW_IDX_INV) begin
                gpio_polarity_invert <= io_req.wdata; // [R10]
            end
        end
    end

    // Pin synchroniser
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else if (clk_en) begin
            pin_meta <= general_io_lines_in;
            pin_sync <= pin_meta;
        end
    end

    // Data bits: input lines follow the pin, output lines take host writes
    always_comb begin
        next_line_value = gpio_line_value;
        for (int i = 0; i < 8; i++) begin
            if (gpio_direction[i]) begin
                next_line_value[i] = pin_sync[i] ^ gpio_polarity_invert[i]; // [R3] [R4]
            end else if (wr_dat && sel_gpio && cfg_index == `SGW_IDX_DATA) begin
                next_line_value[i] = io_req.wdata[i]; // [R2]
            end
        end
    end

    // Data register update, frozen with the clock enable
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpio_line_value <= `SGW_DATA_RST;
        end else if (clk_en) begin
            gpio_line_value <= next_line_value;
        end
    end

    // Pin drive, inverted on the way out
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            general_io_lines_out <= 8'h00;
            general_io_lines_oe  <= 8'h00;
        end else if (clk_en) begin
            general_io_lines_out <= next_line_value ^ gpio_polarity_invert; // [R4]
            general_io_lines_oe  <= ~gpio_direction; // [R1]
        end
    end

    // Read mux for the data port
    always_comb begin
        cfg_rdata = 8'h00;
        if (cfg_index == `SGW_IDX_LDN) begin
            cfg_rdata = logical_device_select;
        end else if (sel_gpio && cfg_index == `SGW_IDX_DIR) begin
            cfg_rdata = gpio_direction;
        end else if (sel_gpio && cfg_index == `SGW_IDX_DATA) begin
            cfg_rdata = gpio_line_value;
        end else if (sel_gpio && cfg_index == `SGW_IDX_INV) begin
            cfg_rdata = gpio_polarity_invert;
        end else if (sel_wdt && cfg_index == `SGW_IDX_ACT) begin
            cfg_rdata = {7'h00, wdt_active};
        end
    end

    // Read answer one cycle after the request; unmapped ports and locked data-port reads give ff, unmapped indexes give 00
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end else if (clk_en) begin
            io_rvalid <= rd;
            if (rd_dat) begin
                io_rdata <= cfg_rdata;
            end else if (rd && io_req.addr == `SGW_WDT_DATA_PORT) begin
                io_rdata <= wdt_count;
            end else if (rd && io_req.addr == `SGW_WDT_BASE_PORT) begin
                io_rdata <= {7'h00, wdt_timeout};
            end else if (rd) begin
                io_rdata <= 8'hff;
            end
        end
    end

    // Watchdog activation in device 8
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_active <= 1'b0;
        end else if (wr_dat && sel_wdt && cfg_index == `SGW_IDX_ACT) begin
            wdt_active <= io_req.wdata[0]; // [R12] [R13]
        end
    end

    // Time unit selection
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_unit <= SGW_U_1S;
        end else if (wr && io_req.addr == `SGW_WDT_BASE_PORT) begin
            if (io_req.wdata == `SGW_UNIT_1S) begin
                wdt_unit <= SGW_U_1S; // [R14]
            end else if (io_req.wdata == `SGW_UNIT_10MS) begin
                wdt_unit <= SGW_U_10MS; // [R15]
            end else if (io_req.wdata == `SGW_UNIT_1MIN) begin
                wdt_unit <= SGW_U_1MIN; // [R15]
            end
        end
    end

    // Prescaler: 10 ms ticks, then units
    always_comb begin
        case (wdt_unit)
            SGW_U_10MS: unit_len = 7'd1;
            SGW_U_1MIN: unit_len = 7'(`SGW_S_PER_MIN);
            default:    unit_len = 7'(`SGW_TICKS_PER_S);
        endcase
    end

    logic tick_pulse;
    logic sec_wrap;
    // 10 ms tick counter; held clear while idle and on every reload
    assign tick_pulse = (tick_cnt == 32'(TICK_10MS - 1));
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= 32'h0;
        end else if (clk_en) begin
            if (!wdt_running || (wr && io_req.addr == `SGW_WDT_DATA_PORT)) begin
                tick_cnt <= 32'h0; // [R18]
            end else if (tick_pulse) begin
                tick_cnt <= 32'h0;
            end else begin
                tick_cnt <= tick_cnt + 32'h1;
            end
        end
    end

    // Seconds within the current minute; only the minute unit reads it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            unit_cnt <= 7'h0;
        end else if (clk_en) begin
            if (!wdt_running || (wr && io_req.addr == `SGW_WDT_DATA_PORT)) begin
                unit_cnt <= 7'h0; // [R18]
            end else if (sec_wrap) begin
                unit_cnt <= unit_pulse ? 7'h0 : unit_cnt + 7'h1; // [R15]
            end
        end
    end

    // Minutes count seconds first: 100 ticks per second, 60 seconds
    logic [6:0] sec_cnt;
    assign sec_wrap = tick_pulse && (sec_cnt == 7'(`SGW_TICKS_PER_S - 1));
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_cnt <= 7'h0;
        end else if (clk_en) begin
            if (!wdt_running || (wr && io_req.addr == `SGW_WDT_DATA_PORT)) begin
                sec_cnt <= 7'h0;
            end else if (tick_pulse) begin
                sec_cnt <= sec_wrap ? 7'h0 : sec_cnt + 7'h1;
            end
        end
    end

    // One pulse per selected time unit
    always_comb begin
        case (wdt_unit)
            SGW_U_10MS: unit_pulse = tick_pulse;
            SGW_U_1MIN: unit_pulse = sec_wrap && (unit_cnt >= unit_len - 7'h1);
            default:    unit_pulse = sec_wrap;
        endcase
    end

    // Counter and timeout status; expiry wins over a clear
    assign expire = wdt_running && wdt_active && unit_pulse && (wdt_count == 8'h01);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_count   <= 8'h00;
            wdt_running <= 1'b0;
            wdt_timeout <= 1'b0;
        end else if (clk_en) begin
            if (wr && io_req.addr == `SGW_WDT_DATA_PORT) begin
                wdt_count   <= io_req.wdata; // [R16]
                wdt_running <= (io_req.wdata != 8'h00);
            end else if (!wdt_active) begin
                wdt_running <= 1'b0; // [R13]
            end else if (wdt_running && unit_pulse) begin
                wdt_count   <= wdt_count - 8'h01; // [R18]
                wdt_running <= !expire;
            end
            // Status flag set at expiry, cleared by a seconds-unit write
            if (expire) begin
                wdt_timeout <= 1'b1; // [R18]
            end else if (wr && io_req.addr == `SGW_WDT_BASE_PORT
                         && io_req.wdata == `SGW_UNIT_1S) begin
                wdt_timeout <= 1'b0; // [R14]
            end
        end
    end

    // Expiry action: one-cycle reset or level interrupt
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_cpu_reset <= 1'b0;
            wdt_irq       <= 1'b0;
        end else if (clk_en) begin
            wdt_cpu_reset <= expire && !wdt_irq_mode; // [R17]
            wdt_irq       <= (wdt_timeout || expire) && wdt_irq_mode; // [R17]
        end
    end
endmodule // sgw_gpio_wdt

/* File: sgw_gpio_wdt_asserts.sv */
`timescale 1ns/100ps
module sgw_gpio_wdt_asserts
    import sgw_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        clk_en,
    input wire sgw_io_req_t io_req,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rvalid,
    input wire logic [7:0]  general_io_lines_in,
    input wire logic [7:0]  general_io_lines_out,
    input wire logic [7:0]  general_io_lines_oe,
    input wire logic        wdt_irq_mode,
    input wire logic        wdt_cpu_reset,
    input wire logic        wdt_irq,
    input wire logic        wdt_timeout
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Host cycle qualifiers
    logic wr_cyc;
    logic clr_wr;
    assign wr_cyc = io_req.wr && clk_en;
    assign clr_wr = wr_cyc && io_req.addr == 16'h0300 && io_req.wdata == 8'h03;
    sequence rd_cyc;
        io_req.rd && clk_en;
    endsequence
    sequence expiry;
        $rose(wdt_timeout);
    endsequence
    // Read answer timing and cause
    rd_answer_a: assert property (rd_cyc |=> io_rvalid)
        else $error("read not answered next cycle");
    rd_cause_a: assert property (io_rvalid |-> $past(io_req.rd && clk_en))
        else $error("read answer without read");
    // Drive enables change only after a host write
    dir_cause_a: assert property ($changed(general_io_lines_oe) |-> $past(wr_cyc, 2))
        else $error("line direction changed without write");
    // Expiry actions
    pulse_one_a: assert property (expiry ##0 !wdt_irq_mode |-> wdt_cpu_reset ##1 !wdt_cpu_reset)
        else $error("cpu reset pulse missing or long");
    rst_mode_a: assert property (wdt_cpu_reset |-> !$past(wdt_irq_mode) && wdt_timeout)
        else $error("cpu reset outside expiry");
    irq_rise_a: assert property (expiry ##0 wdt_irq_mode |-> ##[0:1] wdt_irq)
        else $error("interrupt missing at expiry");
    irq_level_a: assert property (wdt_irq |-> wdt_timeout || $past(wdt_timeout))
        else $error("interrupt without status");
    // Status is sticky until a seconds-unit write clears it
    hold_status_a: assert property (wdt_timeout && !clr_wr |=> wdt_timeout)
        else $error("status lost without clear");
    clear_status_a: assert property (clr_wr && wdt_timeout |=> !wdt_timeout)
        else $error("status not cleared");
endmodule // sgw_gpio_wdt_asserts

bind sgw_gpio_wdt sgw_gpio_wdt_asserts u_sgw_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .general_io_lines_in(general_io_lines_in), .general_io_lines_out(general_io_lines_out),
    .general_io_lines_oe(general_io_lines_oe), .wdt_irq_mode(wdt_irq_mode),
    .wdt_cpu_reset(wdt_cpu_reset), .wdt_irq(wdt_irq), .wdt_timeout(wdt_timeout));

/* File: sgw_host_model.sv */
`timescale 1ns/100ps
module sgw_host_model
    import sgw_pkg::*;
(
    input  wire logic       ref_clk,
    output sgw_io_req_t     io_req,
    input  wire logic [7:0] io_rdata,
    input  wire logic       io_rvalid
);
    // Idle bus at time zero
    initial io_req = '0;
    // Write cycle, then an idle cycle with address and data scrambled
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge ref_clk);
    endtask
    // Read cycle; answer taken at the edge where it stands
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5c};
        @(posedge ref_clk);
        io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha3};
        @(posedge ref_clk);
        ok = io_rvalid;
        d  = io_rdata;
    endtask
    // Key pair to the index port with a foreign cycle between
    task automatic unlock(input logic [15:0] a, input logic [7:0] key);
        logic [7:0] d;
        logic       ok;
        wr(a, key);
        rd(16'h0300, d, ok);
        wr(a, key);
    endtask
endmodule // sgw_host_model

/* File: tb_superio_gpio_watchdog_config.sv */
`timescale 1ns/100ps
module tb_superio_gpio_watchdog_config import sgw_pkg::*;;
    logic ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, irq_mode = 1'b0, saw_rst = 1'b0;
    logic [7:0] pins_in = 8'h5a, io_rdata, pins_out, pins_oe;
    logic io_rvalid, cpu_rst, irq, tmo;
    sgw_io_req_t io_req;
    int fail_count = 0, cmp_count = 0, cyc = 0;

    sgw_gpio_wdt #(.TICK_10MS(10)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .general_io_lines_in(pins_in), .general_io_lines_out(pins_out),
        .general_io_lines_oe(pins_oe), .wdt_irq_mode(irq_mode), .wdt_cpu_reset(cpu_rst),
        .wdt_irq(irq), .wdt_timeout(tmo));
    sgw_host_model host (.ref_clk(ref_clk), .io_req(io_req), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid));

    // Clock, cycle ceiling and reset pulse capture
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cpu_rst === 1'b1) saw_rst <= 1'b1;
        if (cyc == 80000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read a port and compare answer flag and data
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask
    task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
        host.wr(16'h002e, idx);
        host.wr(16'h002f, val);
    endtask
    task automatic rcfg(input logic [7:0] idx, input logic [7:0] exp);
        host.wr(16'h002e, idx);
        rdc(16'h002f, exp);
    endtask
    // Clear status, pick unit, load count, time the expiry
    task automatic wdt_run(input logic [7:0] u, input logic [7:0] c, input int lo, input int hi);
        int n;
        n = 0;
        host.wr(16'h0300, 8'h03);
        host.wr(16'h0300, u);
        host.wr(16'h0301, c);
        while (tmo !== 1'b1 && n < hi + 8) begin
            @(posedge ref_clk);
            n++;
        end
        cmp_count++;
        if (n < lo || n > hi) begin
            fail_count++;
            $display("ERROR t=%0t cycles=%h exp=%h", $time, n, hi);
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rdc(16'h002f, 8'hff);
        host.unlock(16'h002e, 8'h87);
        cfg(8'h07, 8'h07);
        rcfg(8'hf0, 8'hff);
        chk(pins_oe, 8'h00);
        rcfg(8'hf2, 8'h00);
        rcfg(8'hf1, 8'h5a);
        cfg(8'hf0, 8'h0f);
        cfg(8'hf1, 8'ha5);
        rcfg(8'hf1, 8'haa);
        chk(pins_oe, 8'hf0);
        chk(pins_out & 8'hf0, 8'ha0);
        cfg(8'hf2, 8'hff);
        rcfg(8'hf1, 8'ha5);
        chk(pins_out & 8'hf0, 8'h50);
        host.wr(16'h002e, 8'haa);
        host.wr(16'h002f, 8'h00);
        rdc(16'h002f, 8'hff);
        host.unlock(16'h004e, 8'h77);
        host.wr(16'h004e, 8'hf0);
        rdc(16'h004e, 8'hff);
        rdc(16'h004f, 8'h0f);
        host.wr(16'h004e, 8'hf1);
        rdc(16'h004f, 8'ha5);
        cfg(8'h07, 8'h08);
        cfg(8'h30, 8'h01);
        wdt_run(8'h00, 8'h03, 28, 32);
        rdc(16'h0300, 8'h01);
        chk({7'h00, saw_rst}, 8'h01);
        irq_mode <= 1'b1;
        wdt_run(8'h03, 8'h02, 1996, 2004);
        chk({7'h00, irq}, 8'h01);
        wdt_run(8'h05, 8'h01, 59996, 60004);
        cfg(8'h30, 8'h00);
        host.wr(16'h0300, 8'h03);
        rdc(16'h0300, 8'h00);
        host.wr(16'h0300, 8'h00);
        host.wr(16'h0301, 8'h01);
        repeat (40) @(posedge ref_clk);
        chk({7'h00, tmo}, 8'h00);
        print_verdict();
    end
endmodule // tb_superio_gpio_watchdog_config
